// file: wlv_pkg.sv
/*
  Shared constants and types for the write leveling block: register
  offsets, mode register field positions, reset values, response codes,
  timing counts and the state enumeration.
  Assumes a 10 MHz core clock and a 32-bit AXI4-Lite register bus.
*/
package wlv_pkg;

  localparam int unsigned WLV_ADDR_W       = 8;
  localparam int unsigned WLV_LANE_BITS    = 8;

  // register byte offsets
  localparam logic [7:0]  WLV_OFS_MODE1    = 8'h00;
  localparam logic [7:0]  WLV_OFS_STATUS   = 8'h04;
  localparam logic [7:0]  WLV_OFS_COUNT    = 8'h08;

  // mode_reg_one field positions
  localparam int unsigned WLV_MR1_LEVEL    = 7;
  localparam int unsigned WLV_MR1_QOFF     = 12;
  localparam logic        WLV_LEVEL_RST    = 1'b0;
  localparam logic        WLV_QOFF_RST     = 1'b0;

  // status field positions
  localparam int unsigned WLV_ST_ACTIVE    = 0;
  localparam int unsigned WLV_ST_MODBUSY   = 1;
  localparam int unsigned WLV_ST_MRDBUSY   = 2;
  localparam int unsigned WLV_ST_FBVALID   = 3;
  localparam int unsigned WLV_ST_SAMPLE    = 8;

  localparam logic [1:0]  WLV_RESP_OKAY    = 2'h0;
  localparam logic [1:0]  WLV_RESP_SLVERR  = 2'h2;
  localparam logic [31:0] WLV_DATA_ZERO    = 32'h0000_0000;

  // mode register delays in core cycles (10 MHz)
  localparam int unsigned WLV_T_MOD_CYC    = 12;
  localparam int unsigned WLV_T_MRD_CYC    = 4;

  typedef struct packed {
    logic level_en;
    logic qoff;
  } wlv_mr1_t;

  typedef struct packed {
    logic dqs_rtt;
    logic dq_rtt;
  } wlv_rtt_t;

  typedef enum logic [1:0] {
    WLV_IDLE,
    WLV_ENTER,
    WLV_LEVEL,
    WLV_EXIT
  } wlv_state_t;

endpackage : wlv_pkg

// file: wlv_lane_cap.sv
/*
  One byte lane of leveling capture: the clock pair level is sampled on
  each rising strobe edge in the strobe domain and handed to the core
  clock domain by a toggle crossing.
  Assumes the strobe runs only in bursts; its reset is a synchronised
  copy of the core reset and takes effect only while the strobe runs.
*/
`timescale 1ns/1ps
module wlv_lane_cap
  import wlv_pkg::*;
(
  input  wire logic strobe_clk,
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic ck_lvl,
  output logic      sample,
  output logic      edge_seen
);

  logic strb_rst_s1;
  logic strb_rst_n;
  logic cap;
  logic tog;
  logic tog_s1;
  logic tog_s2;
  logic tog_s3;
  logic cap_s1;
  logic cap_s2;

  //////////////////////////////////////////////////////////////////////////
  // strobe domain
  always_ff @(posedge strobe_clk)
  begin
    strb_rst_s1 <= rst_n;
    strb_rst_n  <= strb_rst_s1;
  end

  // level of the clock pair at the strobe rising edge
  always_ff @(posedge strobe_clk)
  begin
    if (!strb_rst_n)
    begin
      cap <= 1'b0;
      tog <= 1'b0;
    end
    else
    begin
      cap <= ck_lvl;
      tog <= ~tog;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // core domain: cap is stable long before the toggle is seen
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      tog_s1    <= 1'b0;
      tog_s2    <= 1'b0;
      tog_s3    <= 1'b0;
      cap_s1    <= 1'b0;
      cap_s2    <= 1'b0;
      sample    <= 1'b0;
      edge_seen <= 1'b0;
    end
    else
    begin
      tog_s1    <= tog;
      tog_s2    <= tog_s1;
      tog_s3    <= tog_s2;
      cap_s1    <= cap;
      cap_s2    <= cap_s1;
      edge_seen <= tog_s2 ^ tog_s3;
      if (tog_s2 ^ tog_s3)
        sample <= cap_s2;
    end
  end

endmodule : wlv_lane_cap

// file: wlv_top.sv
/*
  Write leveling logic of a DDR3 device: mode register one over
  AXI4-Lite, leveling state machine, termination control under ODT and
  per-lane clock feedback on DQ.
  Assumes clk is the controller clock at 10 MHz, strobe_clk bits are the
  per-lane strobes, ck_lvl and odt are raw pins.
*/
// Summary of operation
// - mode_reg_one bit 7 enters and leaves leveling
// - mode_reg_one bit 12 disables DQ output buffers
// - leveling ODT switches only strobe termination
// - DQ undefined right after entering leveling
// - strobe termination applied three clocks after ODT through the synchroniser, not tWLDQSEN
// - strobe edge samples clock, driven on DQ
// - no read strobes driven with feedback
// - DQ undefined until tMOD after exit command
// - MR commands after tMRD, any after tMOD; mode writes inside tMOD are still accepted, only tMRD refuses
// - each byte lane reports its own strobe
`timescale 1ns/1ps
module wlv_top
  import wlv_pkg::*;
#(
  parameter int unsigned LANES   = 2,
  parameter int unsigned T_MOD   = WLV_T_MOD_CYC,
  parameter int unsigned T_MRD   = WLV_T_MRD_CYC
)
(
  input  wire logic                      clk,
  input  wire logic                      rst_n,
  input  wire logic [LANES-1:0]          strobe_clk,
  input  wire logic                      ck_lvl,
  input  wire logic                      odt,
  input  wire logic [WLV_ADDR_W-1:0]     s_axi_awaddr,
  input  wire logic                      s_axi_awvalid,
  output logic                           s_axi_awready,
  input  wire logic [31:0]               s_axi_wdata,
  input  wire logic [3:0]                s_axi_wstrb,
  input  wire logic                      s_axi_wvalid,
  output logic                           s_axi_wready,
  output logic [1:0]                     s_axi_bresp,
  output logic                           s_axi_bvalid,
  input  wire logic                      s_axi_bready,
  input  wire logic [WLV_ADDR_W-1:0]     s_axi_araddr,
  input  wire logic                      s_axi_arvalid,
  output logic                           s_axi_arready,
  output logic [31:0]                    s_axi_rdata,
  output logic [1:0]                     s_axi_rresp,
  output logic                           s_axi_rvalid,
  input  wire logic                      s_axi_rready,
  output logic [LANES*WLV_LANE_BITS-1:0] dq_o,
  output logic                           dq_oe,
  output logic                           dqs_oe,
  output wlv_rtt_t                       rtt_on,
  output logic                           level_active
);

  initial
  begin
    if (LANES < 1 || LANES > 8 || T_MOD < 1 || T_MOD > 255
        || T_MRD < 1 || T_MRD > 255)
      $error("wlv_top: unsupported parameter value");
  end

  localparam logic [7:0] MOD_LOAD = 8'(T_MOD - 1);
  localparam logic [7:0] MRD_LOAD = 8'(T_MRD - 1);

  wlv_state_t                 state;
  wlv_mr1_t                   mr1;
  logic [7:0]                 mod_cnt;
  logic [7:0]                 mrd_cnt;
  logic                       mrd_busy;
  logic                       odt_s1;
  logic                       odt_s2;
  logic [LANES-1:0]           lane_smp;
  logic [LANES-1:0]           lane_edge;
  logic                       fb_valid;
  logic [7:0]                 edge_cnt;
  logic [WLV_ADDR_W-1:0]      aw_addr;
  logic                       aw_full;
  logic [31:0]                w_data;
  logic [3:0]                 w_strb;
  logic                       w_full;
  logic                       wr_fire;
  logic                       mr1_hit;
  logic                       mr1_take;
  wlv_mr1_t                   next_mr1;
  logic [31:0]                status_word;

  //////////////////////////////////////////////////////////////////////////
  // per-lane capture
  genvar gl;
  generate
    for (gl = 0; gl < LANES; gl++)
    begin : g_lane
      wlv_lane_cap u_cap (
        .strobe_clk (strobe_clk[gl]),
        .clk        (clk),
        .rst_n      (rst_n),
        .ck_lvl     (ck_lvl),
        .sample     (lane_smp[gl]),
        .edge_seen  (lane_edge[gl])
      );
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////
  // odt pin synchroniser
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      odt_s1 <= 1'b0;
      odt_s2 <= 1'b0;
    end
    else
    begin
      odt_s1 <= odt;
      odt_s2 <= odt_s1;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // register write path
  assign wr_fire  = aw_full && w_full && !s_axi_bvalid;
  assign mr1_hit  = aw_addr == WLV_OFS_MODE1;
  assign mrd_busy = mrd_cnt != 8'h00;
  // a mode register write inside tMRD of the last one is refused
  assign mr1_take = wr_fire && mr1_hit && !mrd_busy;

  always_comb
  begin
    next_mr1 = mr1;
    if (w_strb[WLV_MR1_LEVEL/8])
      next_mr1.level_en = w_data[WLV_MR1_LEVEL];
    if (w_strb[WLV_MR1_QOFF/8])
      next_mr1.qoff = w_data[WLV_MR1_QOFF];
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= WLV_RESP_OKAY;
      aw_full       <= 1'b0;
      w_full        <= 1'b0;
      aw_addr       <= '0;
      w_data        <= WLV_DATA_ZERO;
      w_strb        <= 4'h0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_addr       <= s_axi_awaddr;
        aw_full       <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_data       <= s_axi_wdata;
        w_strb       <= s_axi_wstrb;
        w_full       <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (wr_fire)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (mr1_hit && !mrd_busy) ? WLV_RESP_OKAY
                                               : WLV_RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid  <= 1'b0;
        aw_full       <= 1'b0;
        w_full        <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      mr1.level_en <= WLV_LEVEL_RST;
      mr1.qoff     <= WLV_QOFF_RST;
    end
    else if (mr1_take)
      mr1 <= next_mr1;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      mrd_cnt <= 8'h00;
    else if (mr1_take)
      mrd_cnt <= MRD_LOAD;
    else if (mrd_busy)
      mrd_cnt <= mrd_cnt - 8'h01;
  end

  //////////////////////////////////////////////////////////////////////////
  // leveling state machine
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      state   <= WLV_IDLE;
      mod_cnt <= 8'h00;
    end
    else
    begin
      unique case (state)
        WLV_IDLE:
          if (mr1_take && next_mr1.level_en)
          begin
            state   <= WLV_ENTER;
            mod_cnt <= MOD_LOAD;
          end
        WLV_ENTER:
          if (mod_cnt == 8'h00)
            state <= WLV_LEVEL;
          else
            mod_cnt <= mod_cnt - 8'h01;
        WLV_LEVEL:
          if (mr1_take && !next_mr1.level_en)
          begin
            state   <= WLV_EXIT;
            mod_cnt <= MOD_LOAD;
          end
        WLV_EXIT:
          if (mod_cnt == 8'h00)
            state <= WLV_IDLE;
          else
            mod_cnt <= mod_cnt - 8'h01;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // feedback and pins
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      fb_valid <= 1'b0;
      edge_cnt <= 8'h00;
    end
    else if (state != WLV_LEVEL)
    begin
      // DQ stays undefined until a first strobe edge is seen
      fb_valid <= 1'b0;
      edge_cnt <= edge_cnt;
    end
    else if (|lane_edge)
    begin
      fb_valid <= 1'b1;
      edge_cnt <= edge_cnt + 8'h01;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      dq_o         <= '0;
      dq_oe        <= 1'b0;
      dqs_oe       <= 1'b0;
      rtt_on       <= '0;
      level_active <= 1'b0;
    end
    else
    begin
      for (int i = 0; i < LANES; i++)
        dq_o[i*WLV_LANE_BITS +: WLV_LANE_BITS] <=
          {WLV_LANE_BITS{lane_smp[i]}};
      // outputs off while disabled, undefined windows shown as released
      dq_oe  <= state == WLV_LEVEL && fb_valid && !mr1.qoff;
      dqs_oe <= 1'b0;
      if (state == WLV_LEVEL)
      begin
        rtt_on.dqs_rtt <= odt_s2;
        rtt_on.dq_rtt  <= 1'b0;
      end
      else if (state == WLV_IDLE)
      begin
        rtt_on.dqs_rtt <= odt_s2;
        rtt_on.dq_rtt  <= odt_s2;
      end
      else
        rtt_on <= '0;
      level_active <= state != WLV_IDLE;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // register read path
  always_comb
  begin
    status_word = WLV_DATA_ZERO;
    status_word[WLV_ST_ACTIVE]  = state == WLV_LEVEL;
    status_word[WLV_ST_MODBUSY] = state == WLV_ENTER || state == WLV_EXIT;
    status_word[WLV_ST_MRDBUSY] = mrd_busy;
    status_word[WLV_ST_FBVALID] = fb_valid;
    status_word[WLV_ST_SAMPLE +: LANES] = lane_smp;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= WLV_DATA_ZERO;
      s_axi_rresp   <= WLV_RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= WLV_RESP_OKAY;
      s_axi_rdata   <= WLV_DATA_ZERO;
      unique case (s_axi_araddr)
        WLV_OFS_MODE1:
        begin
          s_axi_rdata[WLV_MR1_LEVEL] <= mr1.level_en;
          s_axi_rdata[WLV_MR1_QOFF]  <= mr1.qoff;
        end
        WLV_OFS_STATUS:
          s_axi_rdata <= status_word;
        WLV_OFS_COUNT:
          s_axi_rdata[7:0] <= edge_cnt;
        default:
          s_axi_rresp <= WLV_RESP_SLVERR;
      endcase
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  level_entry_a: assert property (
    state == WLV_IDLE && mr1_take && next_mr1.level_en
    |=> state == WLV_ENTER ##[1:256] state == WLV_LEVEL)
    else $error("leveling entry not completed");

  qoff_gate_a: assert property (
    mr1.qoff |=> !dq_oe)
    else $error("dq driven with outputs disabled");

  lev_rtt_a: assert property (
    state == WLV_LEVEL && $past(state == WLV_LEVEL, 2)
    |-> !rtt_on.dq_rtt)
    else $error("dq termination on while leveling");

  strobe_rtt_a: assert property (
    state == WLV_LEVEL && $past(state == WLV_LEVEL)
    |=> rtt_on.dqs_rtt == $past(odt_s2))
    else $error("strobe termination does not follow odt");

  undef_dq_a: assert property (
    state == WLV_EXIT |=> !dq_oe)
    else $error("dq driven inside exit window");

  enter_undef_a: assert property (
    $rose(state == WLV_LEVEL) |-> !fb_valid ##1 !dq_oe)
    else $error("dq driven before first strobe edge");

  no_rd_strobe_a: assert property (
    level_active |-> !dqs_oe)
    else $error("read strobe driven during leveling");

  fb_value_a: assert property (
    state == WLV_LEVEL && lane_edge[0] ##1 1'b1
    |=> dq_o[0] == $past(lane_smp[0]))
    else $error("feedback does not match sampled clock");

  lane_map_a: assert property (
    dq_o[WLV_LANE_BITS-1:0] == {WLV_LANE_BITS{dq_o[0]}})
    else $error("lane bits disagree");

  mrd_refuse_a: assert property (
    wr_fire && mr1_hit && mrd_busy
    |=> s_axi_bresp == WLV_RESP_SLVERR && $stable(mr1))
    else $error("mode write inside tMRD accepted");

  exit_time_a: assert property (
    $rose(state == WLV_EXIT) |-> (state == WLV_EXIT) [*3])
    else $error("exit window too short");

endmodule : wlv_top

// file: wlv_ctl_model.sv
/*
  Controller side of write leveling: one strobe pulse per request on the
  chosen lanes, launched a set delay after the CK rising edge.
  Assumes CK is the core clock and the bench requests pulses by go.
*/
`timescale 1ns/1ps
module wlv_ctl_model
  import wlv_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       go,
  input  wire logic [1:0] lanes,
  input  wire logic [7:0] dly,
  output logic [1:0]      strobe_clk,
  output logic            ck_lvl
);
  assign ck_lvl = clk;
  // single rank only, no commands or termination programming here
  initial
  begin
    strobe_clk = 2'h0;
    #20;
    // three edges inside reset so the lane domains leave reset cleanly
    repeat (6)
    begin
      strobe_clk = ~strobe_clk;
      #80;
    end
    // two more edges after release, or the lane reset never lets go
    wait (rst_n);
    repeat (4)
    begin
      strobe_clk = ~strobe_clk;
      #80;
    end
    forever
    begin
      @(posedge clk);
      if (go)
      begin
        #(dly);
        strobe_clk = lanes;
        #80;
        strobe_clk = 2'h0;
      end
    end
  end
endmodule : wlv_ctl_model

// file: tb_wlv_top.sv
/*
  Self-checking bench for wlv_top: register access, leveling entry and
  exit, termination under ODT and per-lane clock feedback on DQ.
  Assumes wlv_ctl_model drives strobes and the CK level.
*/
`timescale 1ns/1ps
module tb_wlv_top
  import wlv_pkg::*;
;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        odt = 1'b0;
  logic        go = 1'b0;
  logic [1:0]  lanes = 2'h0;
  logic [7:0]  dly = 8'h0A;
  logic [1:0]  strobe_clk;
  logic        ck_lvl;
  logic [7:0]  s_axi_awaddr = 8'h00;
  logic [7:0]  s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_awvalid = 1'b0;
  logic        s_axi_wvalid = 1'b0;
  logic        s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0;
  logic        s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic        s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic [15:0] dq_o;
  logic        dq_oe, dqs_oe, level_active;
  wlv_rtt_t    rtt_on;
  int          num_errors = 0;
  int          tests_run = 0;
  int          np = 0;
  // a longer tMRD lets two back-to-back mode writes fall inside it
  localparam int unsigned TB_T_MRD = 8;

  always #50 clk = ~clk;

  wlv_top #(.T_MRD(TB_T_MRD)) uut (.clk, .rst_n, .strobe_clk, .ck_lvl,
    .odt, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .dq_o,
    .dq_oe, .dqs_oe, .rtt_on, .level_active);
  wlv_ctl_model ctl (.clk, .rst_n, .go, .lanes, .dly, .strobe_clk, .ck_lvl);

  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      num_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic finish_test();
    $display("checks %0d errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : finish_test

  // ready and valid are read at the falling edge so the rising edge
  // acts on the values the slave really presented
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                        input logic [3:0] s, output logic [1:0] r);
    logic aw;
    logic w;
    logic b;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    aw = 1'b1;
    w = 1'b1;
    b = 1'b1;
    while (b)
    begin
      @(negedge clk);
      aw = aw && !s_axi_awready;
      w = w && !s_axi_wready;
      b = !s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge clk);
      s_axi_awvalid <= aw;
      s_axi_wvalid <= w;
      s_axi_bready <= b;
    end
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
                        output logic [1:0] r);
    logic ar;
    logic rd;
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    ar = 1'b1;
    rd = 1'b1;
    while (rd)
    begin
      @(negedge clk);
      ar = ar && !s_axi_arready;
      rd = !s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge clk);
      s_axi_arvalid <= ar;
      s_axi_rready <= rd;
    end
  endtask : axi_rd

  // pulses stay at least 9 clocks apart so each edge is seen
  task automatic pulse(input logic [1:0] l, input logic [7:0] d);
    @(posedge clk);
    lanes <= l;
    dly <= d;
    go <= 1'b1;
    np++;
    @(posedge clk);
    go <= 1'b0;
    repeat (9) @(posedge clk);
  endtask : pulse

  function automatic logic [15:0] exp_dq(input logic [15:0] p,
                                         input logic [1:0] l,
                                         input logic [7:0] d);
    logic b;
    b = (d < 8'd50);
    exp_dq = p;
    if (l[0])
      exp_dq[7:0] = {8{b}};
    if (l[1])
      exp_dq[15:8] = {8{b}};
  endfunction : exp_dq

  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    #500_000;
    num_errors++;
    finish_test();
  end

  initial
  begin
    logic [31:0] rd;
    logic [1:0]  rs;
    logic [15:0] xq;
    logic [7:0]  d;
    logic [1:0]  l;
    logic        pv;
    int          sd;
    sd = $urandom(32'hA0A63E9A);
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    chk({s_axi_awready, s_axi_wready, s_axi_arready, level_active,
         dq_oe, dqs_oe, s_axi_bvalid, s_axi_rvalid}, 8'hE0);
    axi_rd(WLV_OFS_MODE1, rd, rs);
    chk(rd, WLV_DATA_ZERO);
    axi_rd(8'h0C, rd, rs);
    chk(rs, WLV_RESP_SLVERR);
    axi_wr(WLV_OFS_STATUS, 32'h1, 4'hF, rs);
    chk(rs, WLV_RESP_SLVERR);
    axi_wr(WLV_OFS_MODE1, 32'h80, 4'hF, rs);
    chk(rs, WLV_RESP_OKAY);
    axi_wr(WLV_OFS_MODE1, 32'h80, 4'hF, rs);
    chk(rs, WLV_RESP_SLVERR);
    axi_rd(WLV_OFS_STATUS, rd, rs);
    chk(rd[1:0], 2'h2);
    chk({level_active, dq_oe}, 2'h2);
    repeat (WLV_T_MOD_CYC) @(posedge clk);
    odt <= 1'b1;
    repeat (5) @(posedge clk);
    chk(rtt_on, 2'h2);
    axi_rd(WLV_OFS_STATUS, rd, rs);
    chk(rd[0], 1'b1);
    // sweep the strobe delay until feedback turns from 0 to 1
    xq = 16'h0;
    d = 8'd55;
    pv = 1'b0;
    for (int i = 0; i < 6; i++)
    begin
      pulse(2'h3, d);
      xq = exp_dq(xq, 2'h3, d);
      chk(dq_o, xq);
      chk({dq_oe, dqs_oe}, 2'h2);
      if (!pv && xq[0])
        break;
      pv = xq[0];
      d = (d + 8'd20) % 8'd100;
    end
    pulse(2'h1, 8'd15);
    pulse(2'h2, 8'd65);
    chk(dq_o, 16'h00FF);
    xq = 16'h00FF;
    for (int i = 0; i < 20; i++)
    begin
      l = 2'($urandom_range(3, 1));
      d = 8'($urandom_range(40, 5) + 50 * $urandom_range(1, 0));
      pulse(l, d);
      xq = exp_dq(xq, l, d);
      chk(dq_o, xq);
    end
    axi_wr(WLV_OFS_MODE1, 32'h1080, 4'hF, rs);
    pulse(2'h3, 8'd15);
    chk(dq_oe, 1'b0);
    axi_rd(WLV_OFS_MODE1, rd, rs);
    chk(rd, 32'h1080);
    axi_wr(WLV_OFS_MODE1, 32'h0, 4'h2, rs);
    pulse(2'h3, 8'd65);
    chk({dq_oe, dq_o}, 17'h10000);
    odt <= 1'b0;
    repeat (5) @(posedge clk);
    chk(rtt_on, 2'h0);
    axi_wr(WLV_OFS_MODE1, 32'h0, 4'hF, rs);
    repeat (2) @(negedge clk);
    chk({level_active, dq_oe}, 2'h2);
    repeat (WLV_T_MOD_CYC - 3) @(negedge clk);
    chk(level_active, 1'b1);
    repeat (4) @(negedge clk);
    chk(level_active, 1'b0);
    // every pulse fell inside leveling, one count each
    axi_rd(WLV_OFS_COUNT, rd, rs);
    chk(rd, 32'(np));
    finish_test();
  end
endmodule : tb_wlv_top
